// ### inc/cm4x_pkg.sv
// package for the 4x clock multiplier control block
// assumes an 8-bit special-function register port on clk_sys
package cm4x_pkg;
    localparam logic [7:0] CM4X_CTRL_ADDR = 8'hb9;
    localparam logic [7:0] CM4X_CTRL_RESET = 8'h00;
    localparam int CM4X_BIT_ENABLE = 7;
    localparam int CM4X_BIT_INIT = 6;
    localparam int CM4X_BIT_LOCKED = 5;
    localparam int CM4X_SEL_LSB = 0;
    localparam logic [7:0] CM4X_WRITABLE_MASK = 8'hc3;
    localparam logic [1:0] CM4X_SEL_INTERNAL = 2'h0;
    localparam logic [1:0] CM4X_SEL_EXTERNAL = 2'h1;
    localparam logic [1:0] CM4X_SEL_EXT_HALF = 2'h2;
    localparam int CM4X_MULT_FACTOR = 4;
    localparam int CM4X_CLK_MHZ = 50;
    // time for the multiplier loop to settle once initialized, in ns
    localparam int CM4X_LOCK_TIME_NS = 200;
    localparam int CM4X_LOCK_CYCLES = (CM4X_LOCK_TIME_NS * CM4X_CLK_MHZ + 999) / 1000;
    localparam int CM4X_CNT_W = 8;
    typedef enum logic [1:0] {CM4X_OFF, CM4X_POWERED, CM4X_LOCKING, CM4X_LOCKED} cm4x_state_t;
    // register port signals that travel together
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } cm4x_sfr_req_t;
    typedef struct packed {
        logic enable;
        logic initialize;
        logic [1:0] inputSelect;
    } cm4x_ctrl_t;
endpackage

// ### design/cm4x_input_mux.sv
// input source routing for the multiplier reference clock
// sources are sampled enables on clk_sys standing in for the oscillators
`timescale 1ns/1ps
`default_nettype none
module cm4x_input_mux
    import cm4x_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstSync_n,
    input wire logic [1:0] sel,
    input wire logic intTick,
    input wire logic extTick,
    output logic refTick
);
    logic halfToggle_reg;
    logic halfToggle_next;
    logic refTick_next;

    // external halved: pass every second external tick; code 11 routes nothing
    always_comb
    begin
        halfToggle_next = halfToggle_reg ^ extTick;
        case (sel)
            CM4X_SEL_INTERNAL: refTick_next = intTick;
            CM4X_SEL_EXTERNAL: refTick_next = extTick;
            CM4X_SEL_EXT_HALF: refTick_next = extTick & halfToggle_reg;
            default: refTick_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            halfToggle_reg <= 1'b0;
            refTick <= 1'b0;
        end
        else
        begin
            halfToggle_reg <= halfToggle_next;
            refTick <= refTick_next;
        end
    end
endmodule
`default_nettype wire

// ### design/cm4x_clock_multiplier_control.sv
// control register and lock sequencing for the 4x clock multiplier
// assumes a single-cycle SFR port on clk_sys; the external oscillator tick arrives from a pin
`timescale 1ns/1ps
`default_nettype none
module cm4x_clock_multiplier_control
    import cm4x_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire cm4x_sfr_req_t sfrReq,
    output logic [7:0] sfrRdData,
    input wire logic intOscTick,
    input wire logic extOscTick,
    output logic multiplierPowered,
    output logic multiplierLocked,
    output logic usbClkTick,
    output logic sysClkDivTick
);
    logic rstMeta_n;
    logic rstSync_n;
    logic extMeta;
    logic extSync;
    logic refTick;
    cm4x_ctrl_t ctrl_reg;
    cm4x_ctrl_t ctrl_next;
    cm4x_state_t state_reg;
    cm4x_state_t state_next;
    logic [CM4X_CNT_W-1:0] lockCnt_reg;
    logic [CM4X_CNT_W-1:0] lockCnt_next;
    logic [1:0] burst_reg;
    logic [1:0] burst_next;
    logic divTog_reg;
    logic divTog_next;
    logic usbTick_next;
    logic [7:0] rdData_next;
    logic ctrlWrite;

    // reset release through two flops
    // the copy rstSync_n feeds every other flop of the block
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end
        else
        begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // external oscillator comes from a pin, so it is synchronised first
    // only the second flop of the pair is read by any logic
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            extMeta <= 1'b0;
            extSync <= 1'b0;
        end
        else
        begin
            extMeta <= extOscTick;
            extSync <= extMeta;
        end
    end

    // reference routing; select 11 still locks but feeds no reference ticks
    // the mux registers its output, which adds one cycle of tick latency
    cm4x_input_mux u_mux (
        .clk_sys(clk_sys),
        .rstSync_n(rstSync_n),
        .sel(ctrl_reg.inputSelect),
        .intTick(intOscTick),
        .extTick(extSync),
        .refTick(refTick)
    );

    // write strobe aimed at the control register
    assign ctrlWrite = sfrReq.wrEn && (sfrReq.addr == CM4X_CTRL_ADDR);

    // register write; the lock flag is not stored here so it cannot be written
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (ctrlWrite)
        begin
            ctrl_next.enable = sfrReq.wrData[CM4X_BIT_ENABLE];
            ctrl_next.initialize = sfrReq.wrData[CM4X_BIT_INIT];
            ctrl_next.inputSelect = sfrReq.wrData[CM4X_SEL_LSB +: 2];
        end
    end

    // sequencer: off, powered, locking, locked
    always_comb
    begin
        state_next = state_reg;
        lockCnt_next = lockCnt_reg;
        if (ctrlWrite && (sfrReq.wrData == CM4X_CTRL_RESET))
        begin
            state_next = CM4X_OFF;
            lockCnt_next = '0;
        end
        else if (!ctrl_next.enable)
        begin
            state_next = CM4X_OFF;
            lockCnt_next = '0;
        end
        else
        begin
            case (state_reg)
                // the power-up wait before initialize is software's to keep; it is not timed here
                CM4X_OFF: state_next = CM4X_POWERED;
                CM4X_POWERED:
                begin
                    // a rising initialize while enabled starts the lock
                    if (ctrl_next.initialize && !ctrl_reg.initialize)
                    begin
                        state_next = CM4X_LOCKING;
                        lockCnt_next = '0;
                    end
                end
                CM4X_LOCKING:
                begin
                    // lock is a fixed settle count; no loop behaviour is modelled
                    if (lockCnt_reg == CM4X_CNT_W'(CM4X_LOCK_CYCLES - 1))
                        state_next = CM4X_LOCKED;
                    else
                        lockCnt_next = lockCnt_reg + 1'b1;
                end
                CM4X_LOCKED: state_next = CM4X_LOCKED;
                default: state_next = CM4X_OFF;
            endcase
            // select changes while locking or locked would lose lock, so drop back to powered
            if ((state_reg == CM4X_LOCKED || state_reg == CM4X_LOCKING) &&
                (ctrl_next.inputSelect != ctrl_reg.inputSelect))
            begin
                state_next = CM4X_POWERED;
                lockCnt_next = '0;
            end
        end
    end

    // multiplier output model: each reference tick becomes four output ticks
    always_comb
    begin
        burst_next = burst_reg;
        divTog_next = divTog_reg;
        // a tick is flagged only where the burst advances, so clearing a
        // part-done burst on loss of lock does not count as an output tick
        usbTick_next = 1'b0;
        if (state_reg != CM4X_LOCKED)
        begin
            burst_next = 2'h0;
            divTog_next = 1'b0;
        end
        else if (refTick || burst_reg != 2'h0)
        begin
            burst_next = burst_reg + 1'b1;
            usbTick_next = 1'b1;
            divTog_next = ~divTog_reg;
        end
    end

    // read data: lock flag only in the locked state, unused bits zero
    // the read strobe is single-cycle, so the data stands for one cycle only
    always_comb
    begin
        rdData_next = 8'h00;
        if (sfrReq.rdEn && sfrReq.addr == CM4X_CTRL_ADDR)
        begin
            rdData_next[CM4X_BIT_ENABLE] = ctrl_reg.enable;
            rdData_next[CM4X_BIT_INIT] = ctrl_reg.initialize;
            rdData_next[CM4X_BIT_LOCKED] = (state_reg == CM4X_LOCKED);
            rdData_next[CM4X_SEL_LSB +: 2] = ctrl_reg.inputSelect;
        end
    end

    // state and output registers; every port is driven straight from a flop
    // so downstream clock logic never sees decode glitches
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            ctrl_reg <= '0;
            state_reg <= CM4X_OFF;
            lockCnt_reg <= '0;
            burst_reg <= 2'h0;
            divTog_reg <= 1'b0;
            sfrRdData <= 8'h00;
            multiplierPowered <= 1'b0;
            multiplierLocked <= 1'b0;
            usbClkTick <= 1'b0;
            sysClkDivTick <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            state_reg <= state_next;
            lockCnt_reg <= lockCnt_next;
            burst_reg <= burst_next;
            divTog_reg <= divTog_next;
            sfrRdData <= rdData_next;
            multiplierPowered <= (state_next != CM4X_OFF);
            multiplierLocked <= (state_next == CM4X_LOCKED);
            usbClkTick <= usbTick_next;
            sysClkDivTick <= divTog_next & ~divTog_reg;
        end
    end
endmodule
`default_nettype wire

// ### dv/cm4x_ctrl_checker.sv
// assertions for the clock multiplier control block
// sees only the top module ports; bound at the foot of the file
`timescale 1ns/1ps
`default_nettype none
module cm4x_ctrl_checker
    import cm4x_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire cm4x_sfr_req_t sfrReq,
    input wire logic [7:0] sfrRdData,
    input wire logic multiplierPowered,
    input wire logic multiplierLocked,
    input wire logic usbClkTick
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic hit;
    logic rdHit;
    logic wrHit;
    // decode of accesses aimed at the control register
    assign hit = sfrReq.addr == CM4X_CTRL_ADDR;
    assign rdHit = sfrReq.rdEn && hit;
    assign wrHit = sfrReq.wrEn && hit;
    // init only counts from a powered, unlocked state
    sequence s_init;
        wrHit && sfrReq.wrData[7:6] == 2'h3 && multiplierPowered && !multiplierLocked;
    endsequence
    sequence s_lock;
        !multiplierLocked [*7] ##[1:7] multiplierLocked;
    endsequence
    property p_lock; s_init |=> s_lock; endproperty
    a_lock: assert property (p_lock) else $error("lock timing wrong");
    property p_rdz; rdHit |=> sfrRdData[4:2] == 3'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("unused bits set");
    property p_rdlk; rdHit |=> sfrRdData[5] == $past(multiplierLocked); endproperty
    a_rdlk: assert property (p_rdlk) else $error("ready flag differs");
    property p_idle; !rdHit |=> sfrRdData == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_off; wrHit && !sfrReq.wrData[7] |=> !multiplierPowered && !multiplierLocked;
    endproperty
    a_off: assert property (p_off) else $error("not disabled");
    property p_on; wrHit && sfrReq.wrData[7] |=> multiplierPowered; endproperty
    a_on: assert property (p_on) else $error("not powered");
    property p_lkpw; multiplierLocked |-> multiplierPowered; endproperty
    a_lkpw: assert property (p_lkpw) else $error("locked while off");
    property p_usb; usbClkTick |-> multiplierLocked || $past(multiplierLocked); endproperty
    a_usb: assert property (p_usb) else $error("tick while unlocked");
    property p_other; sfrReq.wrEn && !hit |=> $stable(multiplierPowered); endproperty
    a_other: assert property (p_other) else $error("foreign write acted");
endmodule
bind cm4x_clock_multiplier_control cm4x_ctrl_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .sfrReq(sfrReq), .sfrRdData(sfrRdData), .multiplierPowered(multiplierPowered),
    .multiplierLocked(multiplierLocked), .usbClkTick(usbClkTick));
`default_nettype wire

// ### dv/tb_clock_multiplier_4x_control.sv
// self-checking bench for the clock multiplier control block
// drives register port and oscillator ticks; checker is bound separately
`timescale 1ns/1ps
`default_nettype none
module tb_clock_multiplier_4x_control;
    import cm4x_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    cm4x_sfr_req_t sfrReq = '0;
    logic intOscTick = 1'b0;
    logic extOscTick = 1'b0;
    logic [7:0] sfrRdData;
    logic multiplierPowered, multiplierLocked, usbClkTick, sysClkDivTick;
    int failCount = 0;
    int checks = 0;
    int usbCnt = 0;
    int sysCnt = 0;
    int seed = 32'h7603;
    logic [31:0] r;
    always #10 clk_sys = ~clk_sys;
    cm4x_clock_multiplier_control uut (.clk_sys(clk_sys), .rst_n(rst_n), .sfrReq(sfrReq),
        .sfrRdData(sfrRdData), .intOscTick(intOscTick), .extOscTick(extOscTick),
        .multiplierPowered(multiplierPowered), .multiplierLocked(multiplierLocked),
        .usbClkTick(usbClkTick), .sysClkDivTick(sysClkDivTick));
    // tallies for the rate checks
    always @(posedge clk_sys)
    begin
        usbCnt <= usbCnt + usbClkTick;
        sysCnt <= sysCnt + sysClkDivTick;
    end
    task automatic completeRun;
        if (failCount == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            failCount++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        sfrReq = {1'b1, 1'b0, a, d};
        @(posedge clk_sys) #1;
        sfrReq = '0;
    endtask
    // data stands for the one cycle after the read strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys) #1;
        sfrReq = {1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys) #1;
        sfrReq = '0;
        chk(what, exp, sfrRdData);
    endtask
    // usb ticks for 8 internal and 4 external pulses
    function automatic logic [7:0] rate(input logic [1:0] sel);
        return sel == 2'h0 ? 8'd32 : sel == 2'h1 ? 8'd16 : sel == 2'h2 ? 8'd8 : 8'd0;
    endfunction
    // full bring-up; the spare bits written high must not stick
    task automatic bring(input logic [1:0] sel);
        int n;
        wr(CM4X_CTRL_ADDR, 8'h00);
        wr(CM4X_CTRL_ADDR, 8'h9c | sel);
        rd(CM4X_CTRL_ADDR, 8'h80 | sel, "enabled");
        repeat (260) @(posedge clk_sys);
        // the power-up wait of 260 cycles is over, so init may follow
        wr(CM4X_CTRL_ADDR, 8'hc0 | sel);
        n = 0;
        while (sel != 2'h3 && !multiplierLocked && n < 40)
        begin
            @(posedge clk_sys) #1;
            n++;
        end
        if (n == 40)
        begin
            failCount++;
            completeRun();
        end
        if (sel != 2'h3)
            rd(CM4X_CTRL_ADDR, 8'he0 | sel, "locked");
    endtask
    // reference pulses spaced so four output ticks always fit
    task automatic burst(input logic [1:0] sel);
        usbCnt = 0;
        sysCnt = 0;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_sys) #1;
            intOscTick = 1'b1;
            extOscTick = i[0];
            @(posedge clk_sys) #1;
            intOscTick = 1'b0;
            extOscTick = 1'b0;
            repeat (12) @(posedge clk_sys);
        end
        repeat (20) @(posedge clk_sys);
        chk("usb ticks", rate(sel), usbCnt[7:0]);
        chk("sys ticks", rate(sel) / 2, sysCnt[7:0]);
    endtask
    initial
    begin
        #200000;
        failCount++;
        completeRun();
    end
    initial
    begin
        repeat (8) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(CM4X_CTRL_ADDR, CM4X_CTRL_RESET, "reset value");
        for (int s = 0; s < 4; s++)
        begin
            bring(s[1:0]);
            burst(s[1:0]);
        end
        bring(2'h0);
        // foreign addresses must neither act nor answer
        for (int i = 0; i < 6; i++)
        begin
            r = $random(seed);
            if (r[15:8] == CM4X_CTRL_ADDR)
                r[15:8] = 8'h00;
            wr(r[15:8], r[7:0]);
            rd(r[15:8], 8'h00, "foreign read");
        end
        rd(CM4X_CTRL_ADDR, 8'he0, "after foreign");
        // a reset write in mid-burst must stop the output after the ticks already under way
        usbCnt = 0;
        intOscTick = 1'b1;
        @(posedge clk_sys) #1;
        intOscTick = 1'b0;
        wr(CM4X_CTRL_ADDR, 8'h00);
        rd(CM4X_CTRL_ADDR, 8'h00, "reset write");
        chk("cut burst", 8'h02, usbCnt[7:0]);
        completeRun();
    end
endmodule
`default_nettype wire
